// ==== bench/mer_chk.sv ====
// Port checker for the monitor execution responder
`timescale 1ns/1ps
`default_nettype none

module mer_chk (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        rx_valid,
	input wire logic        rd_req,
	input wire logic [4:0]  rd_slot,
	input wire logic        rd_valid,
	input wire logic        rd_ready,
	input wire logic        rd_err,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [7:0]  tx_data
);
	// ============================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	a_reset_quiet: assert property ($rose(rstn) |-> !tx_valid && !rd_req && !rd_ready)
		else $error("output active right after reset");
	a_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("transmit character dropped under back-pressure");
	a_slot_steady: assert property (rd_req && $past(rd_req) |-> $stable(rd_slot))
		else $error("slot number moved during read");
	a_first_kept: assert property (rd_req && rd_valid && !rd_err |-> !rd_ready)
		else $error("first read beat consumed without error");
	a_err_taken: assert property (rd_req && rd_valid && rd_err |-> rd_ready)
		else $error("failing read beat not taken");
	a_err_leaves: assert property (rd_req && rd_valid && rd_ready |=> !rd_req)
		else $error("read request held after failure");
	a_fmt_leaves: assert property (rd_req && rd_valid && !rd_err |-> ##[1:2] !rd_req)
		else $error("read request held after format seen");
	a_req_cause: assert property ($rose(rd_req) |-> $past(rx_valid) || $past(rx_valid, 2)
		|| $past(rx_valid, 3))
		else $error("read request without a received frame");
endmodule

bind mer_top mer_chk i_mer_chk (.mclk(mclk), .rstn(rstn), .rx_valid(rx_valid), .rd_req(rd_req),
	.rd_slot(rd_slot), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_err(rd_err),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

`default_nettype wire

// ==== bench/mer_host.sv ====
// Host computer model: sends request characters, collects responses
`timescale 1ns/1ps
`default_nettype none

module mer_host (
	input  wire logic       mclk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data
);
	logic [7:0] got[$];
	logic [2:0] ph = 3'h0;
	logic       hold = 1'b0;

	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// ============================================================
	// Sink with fixed stalls, so the buffer fills as well as drains
	always @(negedge mclk)
	begin
		ph <= ph + 3'h1;
		tx_ready <= !hold && ph != 3'h0 && ph != 3'h3;
	end
	always @(posedge mclk)
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	// ============================================================
	// One character per cycle; idle line shows the inverse
	task automatic send(input logic [7:0] c);
		@(negedge mclk);
		rx_valid = 1'b1;
		rx_data = c;
	endtask
	task automatic quiet();
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule

`default_nettype wire

// ==== bench/mer_top_tb.sv ====
// Self-checking bench for the monitor execution responder
`timescale 1ns/1ps
`default_nettype none
`include "mer_params.svh"

module mer_top_tb;
	logic        mclk = 1'b0;
	logic        rstn, rx_valid, rd_req, rd_valid, rd_ready, rd_last, rd_err;
	logic        tx_valid, tx_ready, lc, acc;
	logic [1:0]  rd_fmt, mf;
	logic [4:0]  rd_slot, slot_seen;
	logic [7:0]  station_id, rx_data, rd_data, tx_data, sl, d, s1, s0, tl, bd, st;
	logic [15:0] rd_code, cd;
	logic [27:0] beats[$];
	logic [7:0]  exp[$];
	integer      seed = 60487;
	integer      errors = 0;
	integer      n_tests = 0;
	integer      k, n, j;

	always #12.5 mclk = ~mclk;

	mer_top i_mer_top (.mclk(mclk), .rstn(rstn), .station_id(station_id), .rx_valid(rx_valid),
		.rx_data(rx_data), .rd_req(rd_req), .rd_slot(rd_slot), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .rd_last(rd_last), .rd_fmt(rd_fmt),
		.rd_err(rd_err), .rd_code(rd_code), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data));
	mer_host i_mer_host (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

	// ============================================================
	// Slot read provider, stalling at random
	always @(posedge mclk)
	begin
		acc = rd_valid && rd_ready;
		if (acc)
			void'(beats.pop_front());
		if (rd_req)
			slot_seen = rd_slot;
	end
	always @(negedge mclk)
		if (!rd_valid || acc)
		begin
			rd_valid = beats.size() > 0 && ($random(seed) & 3) != 0;
			if (beats.size() > 0)
				{rd_err, rd_code, rd_fmt, rd_last, rd_data} = beats[0];
			else
				rd_data = ~rd_data;
		end

	// ============================================================
	// Expected frames
	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
	endfunction
	function automatic logic [7:0] sum8(input logic [7:0] q[$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i])
			s = s + q[i];
		return s;
	endfunction
	task automatic put2(input logic [7:0] b);
		exp.push_back(hx(b[7:4]));
		exp.push_back(hx(b[3:0]));
	endtask
	task automatic head(input logic [7:0] h);
		exp = {h, hx(station_id[7:4]), hx(station_id[3:0]), lc ? `MER_CMD_LO : `MER_CMD_UP, s1, s0};
	endtask
	task automatic tail();
		exp.push_back(`MER_ETX);
		if (lc)
			put2(sum8(exp));
	endtask
	task automatic frame();
		logic [7:0] q[$];
		logic [7:0] cs;
		q = {`MER_ENQ, hx(st[7:4]), hx(st[3:0]), lc ? `MER_CMD_LO : `MER_CMD_UP, s1, s0, tl};
		// Offset bd spoils the check value on purpose
		cs = sum8(q[0:6]) + bd;
		if (lc)
			q = {q, hx(cs[7:4]), hx(cs[3:0])};
		foreach (q[i])
			i_mer_host.send(q[i]);
		i_mer_host.quiet();
	endtask

	// ============================================================
	// Comparison and closing
	task automatic cmp(input logic [7:0] a, input logic [7:0] b);
		n_tests++;
		if (a !== b)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, a, b);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait, then a quiet spell so extra characters are caught
	task automatic check();
		integer i;
		for (i = 0; i < 3000 && i_mer_host.got.size() < exp.size(); i++)
			@(posedge mclk);
		if (i == 3000)
		begin
			errors++;
			end_of_test();
		end
		repeat (30) @(posedge mclk);
		cmp(8'(i_mer_host.got.size()), 8'(exp.size()));
		foreach (exp[m])
			if (m < i_mer_host.got.size())
				cmp(i_mer_host.got[m], exp[m]);
		i_mer_host.got.delete();
	endtask

	// ============================================================
	// Main sequence
	initial
	begin
		rstn = 1'b0;
		station_id = 8'h1A;
		{rd_valid, rd_err, rd_code, rd_fmt, rd_last, rd_data} = '0;
		repeat (20) @(negedge mclk);
		rstn = 1'b1;
		for (k = 0; k < 12; k++)
		begin
			lc = k >= 6;
			mf = 2'(k % 3 + 1);
			sl = 8'($random(seed)) & `MER_SLOT_MAX;
			sl = (k == 0) ? `MER_SLOT_MAX : sl;
			n = ($random(seed) & 3) + 1;
			{s1, s0, st, tl, bd} = {hx(sl[7:4]), hx(sl[3:0]), station_id, `MER_EOT, 8'h00};
			head(`MER_ACK);
			beats.push_back({1'b0, 16'h0000, mf, 1'b0, 8'h01});
			if (mf != mer_pkg::MER_FMT_CONT)
				put2(8'h01);
			beats.push_back({1'b0, 16'h0000, mf, 1'b0, 8'(n)});
			put2(8'(n));
			for (j = 0; j < n; j++)
			begin
				d = 8'($random(seed));
				beats.push_back({1'b0, 16'h0000, mf, j == n - 1, d});
				put2(d);
			end
			tail();
			i_mer_host.hold = k == 5;
			frame();
			repeat (40) @(negedge mclk);
			i_mer_host.hold = 1'b0;
			check();
			cmp({3'h0, slot_seen}, sl);
			$display("read test %0d done", k);
		end
		// Corners: lower case hex slot, non-hex slot, junk before the header
		for (k = 0; k < 8; k++)
		begin
			lc = k[0];
			cd = 16'($random(seed));
			cd = (k == 2) ? `MER_ERR_MON : (k == 3) ? `MER_ERR_BCC : (k == 4) ? `MER_ERR_SYN : cd;
			cd = (k == 6) ? `MER_ERR_MON : cd;
			s1 = (k == 2) ? 8'h32 : (k == 6) ? 8'h47 : 8'h31;
			s0 = (k == 2) ? 8'h30 : (k == 1) ? 8'h66 : 8'h46;
			tl = (k == 4) ? `MER_ETX : `MER_EOT;
			bd = (k == 3) ? 8'h01 : 8'h00;
			st = (k == 5) ? station_id + 8'h01 : station_id;
			if (k < 2 || k == 7)
				beats.push_back({1'b1, cd, 2'h0, 1'b1, 8'h00});
			head(`MER_NAK);
			put2(cd[15:8]);
			put2(cd[7:0]);
			tail();
			if (k == 5)
				exp.delete();
			if (k == 7)
				i_mer_host.send(`MER_ETX);
			frame();
			check();
			if (k < 2 || k == 7)
				cmp({3'h0, slot_seen}, 8'h1F);
			$display("refusal test %0d done", k);
		end
		end_of_test();
	end
endmodule

`default_nettype wire

// ==== rtl/mer_fifo.sv ====
// Small synchronous FIFO for transmit characters
`timescale 1ns/1ps
`default_nettype none

module mer_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic mclk,
	input  wire logic rstn,
	mer_if.fifo_side  bus
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [PW-1:0]    wptr_r;
	logic [PW-1:0]    wptr_nxt;
	logic [PW-1:0]    rptr_r;
	logic [PW-1:0]    rptr_nxt;
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic             wr;
	logic             rd;

	// ============================================================
	// Handshake
	assign bus.in_ready  = (cnt_r != CW'(DEPTH));
	assign bus.out_valid = (cnt_r != '0);
	assign bus.out_data  = mem_r[rptr_r];
	assign wr = bus.in_valid & bus.in_ready;
	assign rd = bus.out_valid & bus.out_ready;

	// ============================================================
	// Next state
	always_comb
	begin
		mem_nxt  = mem_r;
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		cnt_nxt  = cnt_r;
		if (wr)
		begin
			mem_nxt[wptr_r] = bus.in_data;
			wptr_nxt = (wptr_r == PW'(DEPTH - 1)) ? '0 : wptr_r + PW'(1);
		end
		if (rd)
			rptr_nxt = (rptr_r == PW'(DEPTH - 1)) ? '0 : rptr_r + PW'(1);
		if (wr & ~rd)
			cnt_nxt = cnt_r + CW'(1);
		else if (rd & ~wr)
			cnt_nxt = cnt_r - CW'(1);
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r  <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
		end
		else
		begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r  <= cnt_nxt;
			mem_r  <= mem_nxt;
		end
	end
endmodule

`default_nettype wire

// ==== rtl/mer_if.sv ====
// Stream carrier between the responder and its transmit buffer
`timescale 1ns/1ps
`default_nettype none

interface mer_if #(parameter int W = 8);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;

	modport fill (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
	modport fifo_side (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface

`default_nettype wire

// ==== rtl/mer_params.svh ====
// Constants for the monitor execution responder
`ifndef MER_PARAMS_SVH
`define MER_PARAMS_SVH

// ============================================================
// Control characters
`define MER_ENQ      8'h05
`define MER_EOT      8'h04
`define MER_ACK      8'h06
`define MER_NAK      8'h15
`define MER_ETX      8'h03
`define MER_CMD_UP   8'h59
`define MER_CMD_LO   8'h79

// ============================================================
// Limits and error codes
`define MER_SLOT_MAX 8'h1F
`define MER_ERR_MON  16'h0190
`define MER_ERR_BCC  16'h6050
`define MER_ERR_SYN  16'h6030

// ============================================================
// Buffering
`define MER_FIFO_W   8
`define MER_FIFO_D   4

`endif

// ==== rtl/mer_pkg.sv ====
// Types of the monitor execution responder
package mer_pkg;

	// ============================================================
	// Slot read formats
	typedef enum logic [1:0]
	{
		MER_FMT_NONE  = 2'h0,
		MER_FMT_SEP   = 2'h1,
		MER_FMT_CONT  = 2'h2,
		MER_FMT_NAMED = 2'h3
	} mer_fmt_t;

	// ============================================================
	// Sequencer states
	typedef enum logic [14:0]
	{
		MER_HUNT = 15'h0001,
		MER_ST0  = 15'h0002,
		MER_ST1  = 15'h0004,
		MER_CMD  = 15'h0008,
		MER_SL0  = 15'h0010,
		MER_SL1  = 15'h0020,
		MER_EOT  = 15'h0040,
		MER_BC0  = 15'h0080,
		MER_BC1  = 15'h0100,
		MER_LOOK = 15'h0200,
		MER_HDR  = 15'h0400,
		MER_DATA = 15'h0800,
		MER_CODE = 15'h1000,
		MER_TAIL = 15'h2000,
		MER_BCC  = 15'h4000
	} mer_state_t;

endpackage

// ==== rtl/mer_top.sv ====
// Monitor execution command responder
//
// Operation
// - Request names a slot; the read stored in that slot is performed
// - Lower case request check is low byte of sum ENQ through EOT
// - Acknowledge starts ACK, ends ETX, echoes station, command and slot
// - Separate read payload: block count, then per block count and data
// - Continuous read payload: data count and data, no block count
// - Named read payload: block count, then per block count and data
// - Counts and data go as two ASCII hex characters per byte
// - Lower case acknowledge check is low byte of sum ACK through ETX
// - Failure reply: NAK, echoes, four character error code, ETX
// - Lower case negative check is low byte of sum NAK through ETX
// - Slot contents come from registration, up to 32 slots
// - Slot number out of range answers NAK with monitor error code
// - Bad check answers check error; missing end answers syntax error
`timescale 1ns/1ps
`default_nettype none
`include "mer_params.svh"

module mer_top (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [7:0] station_id,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	output logic            rd_req,
	output logic [4:0]      rd_slot,
	input  wire logic       rd_valid,
	output logic            rd_ready,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_last,
	input  wire logic [1:0] rd_fmt,
	input  wire logic       rd_err,
	input  wire logic [15:0] rd_code,
	output logic            tx_valid,
	input  wire logic       tx_ready,
	output logic [7:0]      tx_data
);
	mer_if #(.W(`MER_FIFO_W)) txq ();

	mer_pkg::mer_state_t st_r, st_nxt;
	logic [7:0]  sta0_r, sta0_nxt, sta1_r, sta1_nxt, cmd_r, cmd_nxt;
	logic [7:0]  sl0_r, sl0_nxt, sl1_r, sl1_nxt, slot_r, slot_nxt;
	logic        slok_r, slok_nxt, lower_r, lower_nxt;
	logic [7:0]  rsum_r, rsum_nxt, rbcc_r, rbcc_nxt, tsum_r, tsum_nxt;
	logic [2:0]  idx_r, idx_nxt;
	logic [7:0]  byte_r, byte_nxt;
	logic        have_r, have_nxt, half_r, half_nxt, last_r, last_nxt;
	logic        skip_r, skip_nxt, nak_r, nak_nxt;
	logic [15:0] code_r, code_nxt;
	logic        emit;
	logic [7:0]  ech;
	logic        push;
	logic        rxv;
	logic [4:0]  hv;
	logic        bcc_ok;

	// ============================================================
	// Hex helpers
	function automatic logic [7:0] to_hex(input logic [3:0] n);
		to_hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	function automatic logic [4:0] from_hex(input logic [7:0] c);
		from_hex = 5'h00;
		if (c >= 8'h30 && c <= 8'h39)
			from_hex = {1'b1, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46)
			from_hex = {1'b1, 4'(c - 8'h37)};
		else if (c >= 8'h61 && c <= 8'h66)
			from_hex = {1'b1, 4'(c - 8'h57)};
	endfunction

	assign rxv    = rx_valid;
	assign hv     = from_hex(rx_data);
	assign bcc_ok = (rbcc_r == rsum_r);

	// ============================================================
	// Transmit buffer, the sequencer stalls while it is full
	assign txq.in_valid  = emit;
	assign txq.in_data   = ech;
	assign push          = emit & txq.in_ready;
	assign txq.out_ready = tx_ready;
	assign tx_valid      = txq.out_valid;
	assign tx_data       = txq.out_data;

	mer_fifo #(.WIDTH(`MER_FIFO_W), .DEPTH(`MER_FIFO_D)) u_fifo (
		.mclk (mclk),
		.rstn (rstn),
		.bus  (txq)
	);

	// ============================================================
	// Slot read port
	assign rd_req  = (st_r == mer_pkg::MER_LOOK);
	assign rd_slot = slot_r[4:0];
	assign rd_ready = (st_r == mer_pkg::MER_LOOK && rd_err)
		|| (st_r == mer_pkg::MER_DATA && !have_r);

	// ============================================================
	// Character to send
	always_comb
	begin
		emit = 1'b0;
		ech  = 8'h00;
		case (st_r)
			mer_pkg::MER_HDR:
			begin
				emit = 1'b1;
				case (idx_r)
					3'h0: ech = nak_r ? `MER_NAK : `MER_ACK;
					3'h1: ech = sta0_r;
					3'h2: ech = sta1_r;
					3'h3: ech = cmd_r;
					3'h4: ech = sl0_r;
					default: ech = sl1_r;
				endcase
			end
			mer_pkg::MER_DATA:
			begin
				emit = have_r;
				ech  = half_r ? to_hex(byte_r[3:0]) : to_hex(byte_r[7:4]);
			end
			mer_pkg::MER_CODE:
			begin
				emit = 1'b1;
				ech  = to_hex(code_r[4'(15 - 4 * idx_r) -: 4]);
			end
			mer_pkg::MER_TAIL:
			begin
				emit = 1'b1;
				ech  = `MER_ETX;
			end
			mer_pkg::MER_BCC:
			begin
				emit = 1'b1;
				ech  = idx_r[0] ? to_hex(tsum_r[3:0]) : to_hex(tsum_r[7:4]);
			end
			default:
			begin
				emit = 1'b0;
				ech  = 8'h00;
			end
		endcase
	end

	// ============================================================
	// Sequencer next state
	always_comb
	begin
		st_nxt = st_r;  sta0_nxt = sta0_r; sta1_nxt = sta1_r; cmd_nxt = cmd_r;
		sl0_nxt = sl0_r; sl1_nxt = sl1_r; slot_nxt = slot_r; slok_nxt = slok_r;
		lower_nxt = lower_r; rsum_nxt = rsum_r; rbcc_nxt = rbcc_r;
		tsum_nxt = tsum_r; idx_nxt = idx_r; byte_nxt = byte_r; have_nxt = have_r;
		half_nxt = half_r; last_nxt = last_r; skip_nxt = skip_r; nak_nxt = nak_r;
		code_nxt = code_r;
		if (push && st_r != mer_pkg::MER_BCC)
			tsum_nxt = tsum_r + ech;
		case (st_r)
			mer_pkg::MER_HUNT:
				if (rxv && rx_data == `MER_ENQ)
				begin
					rsum_nxt = rx_data;
					st_nxt   = mer_pkg::MER_ST0;
				end
			mer_pkg::MER_ST0:
				if (rxv)
				begin
					sta0_nxt = rx_data;
					rsum_nxt = rsum_r + rx_data;
					st_nxt   = mer_pkg::MER_ST1;
				end
			mer_pkg::MER_ST1:
				if (rxv)
				begin
					sta1_nxt = rx_data;
					rsum_nxt = rsum_r + rx_data;
					// Another station's traffic is dropped silently
					if (from_hex(sta0_r) == {1'b1, station_id[7:4]} && hv == {1'b1, station_id[3:0]})
						st_nxt = mer_pkg::MER_CMD;
					else
						st_nxt = mer_pkg::MER_HUNT;
				end
			mer_pkg::MER_CMD:
				if (rxv)
				begin
					cmd_nxt   = rx_data;
					lower_nxt = (rx_data == `MER_CMD_LO);
					rsum_nxt  = rsum_r + rx_data;
					// Other commands belong to other handlers
					st_nxt = (rx_data == `MER_CMD_UP || rx_data == `MER_CMD_LO)
						? mer_pkg::MER_SL0 : mer_pkg::MER_HUNT;
				end
			mer_pkg::MER_SL0:
				if (rxv)
				begin
					sl0_nxt  = rx_data;
					slok_nxt = hv[4];
					slot_nxt = {hv[3:0], 4'h0};
					rsum_nxt = rsum_r + rx_data;
					st_nxt   = mer_pkg::MER_SL1;
				end
			mer_pkg::MER_SL1:
				if (rxv)
				begin
					sl1_nxt  = rx_data;
					slok_nxt = slok_r & hv[4];
					slot_nxt = {slot_r[7:4], hv[3:0]};
					rsum_nxt = rsum_r + rx_data;
					st_nxt   = mer_pkg::MER_EOT;
				end
			mer_pkg::MER_EOT:
				if (rxv)
				begin
					idx_nxt  = 3'h0;
					tsum_nxt = 8'h00;
					rsum_nxt = rsum_r + rx_data;
					if (rx_data != `MER_EOT)
					begin
						nak_nxt  = 1'b1;
						code_nxt = `MER_ERR_SYN;
						st_nxt   = mer_pkg::MER_HDR;
					end
					else if (lower_r)
						st_nxt = mer_pkg::MER_BC0;
					else if (!slok_r || slot_r > `MER_SLOT_MAX)
					begin
						nak_nxt  = 1'b1;
						code_nxt = `MER_ERR_MON;
						st_nxt   = mer_pkg::MER_HDR;
					end
					else
					begin
						nak_nxt = 1'b0;
						st_nxt  = mer_pkg::MER_LOOK;
					end
				end
			mer_pkg::MER_BC0:
				if (rxv)
				begin
					rbcc_nxt = {hv[3:0], 4'h0};
					slok_nxt = slok_r;
					half_nxt = hv[4];
					st_nxt   = mer_pkg::MER_BC1;
				end
			mer_pkg::MER_BC1:
				if (rxv)
				begin
					rbcc_nxt = {rbcc_r[7:4], hv[3:0]};
					if (!(half_r && hv[4]) || {rbcc_r[7:4], hv[3:0]} != rsum_r)
					begin
						nak_nxt  = 1'b1;
						code_nxt = `MER_ERR_BCC;
						st_nxt   = mer_pkg::MER_HDR;
					end
					else if (!slok_r || slot_r > `MER_SLOT_MAX)
					begin
						nak_nxt  = 1'b1;
						code_nxt = `MER_ERR_MON;
						st_nxt   = mer_pkg::MER_HDR;
					end
					else
					begin
						nak_nxt = 1'b0;
						st_nxt  = mer_pkg::MER_LOOK;
					end
				end
			mer_pkg::MER_LOOK:
				if (rd_valid)
				begin
					nak_nxt  = rd_err;
					code_nxt = rd_code;
					// Continuous reads drop the leading block count
					skip_nxt = (rd_fmt == mer_pkg::MER_FMT_CONT);
					have_nxt = 1'b0;
					half_nxt = 1'b0;
					st_nxt   = mer_pkg::MER_HDR;
				end
			mer_pkg::MER_HDR:
				if (push)
				begin
					idx_nxt = idx_r + 3'h1;
					if (idx_r == 3'h5)
					begin
						idx_nxt = 3'h0;
						st_nxt  = nak_r ? mer_pkg::MER_CODE : mer_pkg::MER_DATA;
					end
				end
			mer_pkg::MER_DATA:
				if (!have_r)
				begin
					if (rd_valid)
					begin
						skip_nxt = 1'b0;
						if (skip_r && !rd_last)
							have_nxt = 1'b0;
						else
						begin
							have_nxt = !skip_r;
							byte_nxt = rd_data;
							last_nxt = rd_last;
							half_nxt = 1'b0;
							if (skip_r)
								st_nxt = mer_pkg::MER_TAIL;
						end
					end
				end
				else if (push)
				begin
					half_nxt = ~half_r;
					if (half_r)
					begin
						have_nxt = 1'b0;
						if (last_r)
							st_nxt = mer_pkg::MER_TAIL;
					end
				end
			mer_pkg::MER_CODE:
				if (push)
				begin
					idx_nxt = idx_r + 3'h1;
					if (idx_r == 3'h3)
						st_nxt = mer_pkg::MER_TAIL;
				end
			mer_pkg::MER_TAIL:
				if (push)
				begin
					idx_nxt = 3'h0;
					st_nxt  = lower_r ? mer_pkg::MER_BCC : mer_pkg::MER_HUNT;
				end
			mer_pkg::MER_BCC:
				if (push)
				begin
					idx_nxt = idx_r + 3'h1;
					if (idx_r[0])
						st_nxt = mer_pkg::MER_HUNT;
				end
			default:
				st_nxt = mer_pkg::MER_HUNT;
		endcase
	end

	// ============================================================
	// Sequencer registers
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			st_r <= mer_pkg::MER_HUNT; sta0_r <= 8'h00; sta1_r <= 8'h00;
			cmd_r <= 8'h00; sl0_r <= 8'h00; sl1_r <= 8'h00; slot_r <= 8'h00;
			slok_r <= 1'b0; lower_r <= 1'b0; rsum_r <= 8'h00; rbcc_r <= 8'h00;
			tsum_r <= 8'h00; idx_r <= 3'h0; byte_r <= 8'h00; have_r <= 1'b0;
			half_r <= 1'b0; last_r <= 1'b0; skip_r <= 1'b0; nak_r <= 1'b0;
			code_r <= 16'h0000;
		end
		else
		begin
			st_r <= st_nxt; sta0_r <= sta0_nxt; sta1_r <= sta1_nxt;
			cmd_r <= cmd_nxt; sl0_r <= sl0_nxt; sl1_r <= sl1_nxt; slot_r <= slot_nxt;
			slok_r <= slok_nxt; lower_r <= lower_nxt; rsum_r <= rsum_nxt;
			rbcc_r <= rbcc_nxt; tsum_r <= tsum_nxt; idx_r <= idx_nxt;
			byte_r <= byte_nxt; have_r <= have_nxt; half_r <= half_nxt;
			last_r <= last_nxt; skip_r <= skip_nxt; nak_r <= nak_nxt;
			code_r <= code_nxt;
		end
	end

	logic unused_ok;
	assign unused_ok = bcc_ok;
endmodule

`default_nettype wire
